// ===== logic/nhr_framer.sv
// Frame builder and parser: high-rate reader frames and 106 kb/s transport
// frames, with a 96-byte FIFO and an 8-bit register port.
// Assumes the modulator and demodulator byte streams run on ref_clk;
// the external field detector pin is asynchronous.
`timescale 1ns/1ps
`include "nhr_cfg.svh"
module nhr_framer
  import nhr_pkg::*;
#(
  parameter int unsigned GUARD_CYCLES = `NHR_GUARD_CYCLES
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [7:0]        reg_rdata,
  input  wire nhr_rx_link_t rx_in,
  input  wire logic         tx_ready,
  output nhr_tx_link_t      tx_out,
  input  wire logic         ext_field_pin,
  output logic              field_on,
  output logic [1:0]        rate_div,
  output logic              mod_am
);
  localparam int GW = $clog2(GUARD_CYCLES + 1);

  nhr_state_t     state;
  nhr_state_t     next_state;
  logic [7:0]     ctrl;
  logic [7:0]     txc_lo;
  logic [7:0]     txc_hi;
  logic [7:0]     flags;
  logic [7:0]     fifo_mem [0:95];
  logic [6:0]     wptr;
  logic [6:0]     rptr;
  logic [6:0]     fcount;
  logic           efd_meta;
  logic           efd;
  logic [15:0]    crc;
  logic [15:0]    next_crc;
  logic [12:0]    cnt;
  logic [12:0]    next_cnt;
  logic [7:0]     set_fsm;
  logic           fifo_rx_wr;
  logic           fifo_tx_rd;
  logic [GW-1:0]  guard_cnt;

  // Bit-serial CRC over one byte, MSB first, non-reflected
  function automatic logic [15:0] crc_hr(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ `NHR_CRC_HR_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // Reflected CRC, LSB first
  function automatic logic [15:0] crc_a(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `NHR_CRC_A_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Pointer wrap at the FIFO depth
  function automatic logic [6:0] ptr_inc(input logic [6:0] p);
    return (p == `NHR_FIFO_DEPTH - 7'h01) ? 7'h00 : p + 7'h01;
  endfunction

  // Preamble length in bytes from the two select bits
  function automatic logic [12:0] pre_bytes(input logic [1:0] sel);
    case (sel)
      2'h0:    return `NHR_PRE_B0;
      2'h1:    return `NHR_PRE_B1;
      2'h2:    return `NHR_PRE_B2;
      default: return `NHR_PRE_B3;
    endcase
  endfunction

  // Mode decode
  wire         a106     = (ctrl[1:0] == NHR_A106);
  wire         hr       = !a106;
  wire         tf106    = a106 && ctrl[`NHR_BIT_TF106];
  wire         plain    = a106 && !tf106;
  wire [1:0]   pre_sel  = {ctrl[`NHR_BIT_PRE_HI], ctrl[`NHR_BIT_PRE_LO]};
  wire [12:0]  txcount  = {txc_hi[4:0], txc_lo};
  wire [7:0]   len_tx   = txc_lo + 8'h01;
  wire         guard_busy = (guard_cnt != '0);

  // Register decode, shared by reads and writes
  wire sel_ctrl  = (reg_addr == `NHR_OFF_CTRL);
  wire sel_txlo  = (reg_addr == `NHR_OFF_TXC_LO);
  wire sel_txhi  = (reg_addr == `NHR_OFF_TXC_HI);
  wire sel_cmd   = (reg_addr == `NHR_OFF_CMD);
  wire sel_fifo  = (reg_addr == `NHR_OFF_FIFO);
  wire sel_fst1  = (reg_addr == `NHR_OFF_FST1);
  wire sel_fst2  = (reg_addr == `NHR_OFF_FST2);
  wire sel_flags = (reg_addr == `NHR_OFF_FLAGS);
  wire sel_stat  = (reg_addr == `NHR_OFF_STAT);

  // Commands; a transmit is only taken when idle and the guard has run out
  wire wr_cmd   = reg_wr && sel_cmd;
  wire cmd_tx   = wr_cmd && (reg_wdata == `NHR_CMD_TX_CRC)
                  && (state == NHR_IDLE) && !guard_busy;
  wire cmd_fon  = wr_cmd && (reg_wdata == `NHR_CMD_FON);
  wire cmd_foff = wr_cmd && (reg_wdata == `NHR_CMD_FOFF);
  wire cmd_fclr = wr_cmd && (reg_wdata == `NHR_CMD_FCLR);
  wire fon_ok   = cmd_fon && !efd && !field_on;

  // FIFO bookkeeping; the framer wins over the host on each port
  wire fifo_empty = (fcount == 7'h00);
  wire fifo_full  = (fcount == `NHR_FIFO_DEPTH);
  wire host_wr    = reg_wr && sel_fifo && !fifo_rx_wr;
  wire host_rd    = reg_rd && sel_fifo && !fifo_tx_rd && !fifo_empty;
  wire fifo_req   = fifo_rx_wr || host_wr;
  wire fifo_we    = fifo_req && !fifo_full;
  wire fifo_re    = fifo_tx_rd || host_rd;
  wire [7:0] fifo_wdata = fifo_rx_wr ? rx_in.data : reg_wdata;
  wire [7:0] fifo_head  = fifo_mem[rptr];

  // Byte offered to the modulator in each transmit state
  wire tx_busy = (state >= NHR_TX_PRE) && (state <= NHR_TX_CRC2);
  wire tx_load = tx_busy && (!tx_out.valid || tx_ready)
                 && !((state == NHR_TX_DATA) && fifo_empty);
  wire [7:0] tx_byte =
      (state == NHR_TX_SYN1) ? `NHR_SYNC1 :
      (state == NHR_TX_SYN2) ? `NHR_SYNC2 :
      (state == NHR_TX_SB)   ? `NHR_SB :
      (state == NHR_TX_LEN)  ? len_tx :
      (state == NHR_TX_DATA) ? fifo_head :
      (state == NHR_TX_CRC1) ? (hr ? crc[15:8] : crc[7:0]) :
      (state == NHR_TX_CRC2) ? (hr ? crc[7:0] : crc[15:8]) : 8'h00;

  // One CRC engine serves both directions, the link is half duplex
  wire [7:0]  crc_byte = tx_busy ? tx_byte : rx_in.data;
  wire [15:0] crc_step = hr ? crc_hr(crc, crc_byte) : crc_a(crc, crc_byte);
  wire [15:0] crc_init = hr ? `NHR_CRC_HR_INIT : `NHR_CRC_A_INIT;

  // Flag sources outside the sequencer
  wire [7:0] set_misc = ({7'h00, cmd_fon && efd} << `NHR_F_REFUSE)
                      | ({7'h00, guard_cnt == GW'(1)} << `NHR_F_GUARD)
                      | ({7'h00, fifo_req && fifo_full} << `NHR_F_OVF);
  wire [7:0] set_all  = set_fsm | set_misc;
  wire [7:0] clr_all  = (reg_wr && sel_flags) ? reg_wdata : 8'h00;

  // Read data selection
  wire [7:0] rd_mux =
      sel_ctrl  ? ctrl :
      sel_txlo  ? txc_lo :
      sel_txhi  ? {3'h0, txc_hi[4:0]} :
      sel_fifo  ? (fifo_empty ? 8'h00 : fifo_head) :
      sel_fst1  ? {1'b0, fcount} :
      sel_fst2  ? {7'h00, flags[`NHR_F_OVF]} :
      sel_flags ? flags :
      sel_stat  ? {efd, field_on, guard_busy, 1'b0, state} : 8'h00;

  // Frame sequencer
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_crc   = crc;
    set_fsm    = 8'h00;
    fifo_rx_wr = 1'b0;
    fifo_tx_rd = 1'b0;
    case (state)
      NHR_IDLE: begin
        if (cmd_tx) begin
          next_crc = crc_init;
          if (tf106) begin
            next_state = NHR_TX_SB;
          end else if (hr) begin
            next_state = NHR_TX_PRE;
            next_cnt   = pre_bytes(pre_sel);
          end else begin
            next_state = (txcount == 13'h0000) ? NHR_TX_CRC1 : NHR_TX_DATA;
            next_cnt   = txcount;
          end
        end
      end
      NHR_TX_PRE: begin
        if (tx_load) begin
          next_cnt = cnt - 13'h0001;
          if (cnt == 13'h0001) next_state = NHR_TX_SYN1;
        end
      end
      NHR_TX_SYN1: if (tx_load) next_state = NHR_TX_SYN2;
      NHR_TX_SYN2: if (tx_load) next_state = NHR_TX_LEN;
      NHR_TX_SB: begin
        if (tx_load) begin
          next_crc   = crc_step;
          next_state = NHR_TX_LEN;
        end
      end
      NHR_TX_LEN: begin
        if (tx_load) begin
          next_crc   = crc_step;
          next_cnt   = txcount;
          next_state = (txcount == 13'h0000) ? NHR_TX_CRC1 : NHR_TX_DATA;
        end
      end
      NHR_TX_DATA: begin
        if (tx_load) begin
          next_crc   = crc_step;
          fifo_tx_rd = 1'b1;
          next_cnt   = cnt - 13'h0001;
          if (cnt == 13'h0001) next_state = NHR_TX_CRC1;
        end
      end
      NHR_TX_CRC1: if (tx_load) next_state = NHR_TX_CRC2;
      NHR_TX_CRC2: if (tx_load) next_state = NHR_TX_END;
      NHR_TX_END: begin
        if (tx_ready) begin
          set_fsm[`NHR_F_TX_DONE] = 1'b1;
          next_state = NHR_RX_HUNT;
          next_cnt   = 13'h0000;
          next_crc   = crc_init;
        end
      end
      NHR_RX_HUNT: begin
        if (rx_in.valid) begin
          if (tf106) begin
            next_crc   = crc_step;
            next_state = NHR_RX_LEN;
            if (rx_in.data != `NHR_SB) set_fsm[`NHR_F_SOFT] = 1'b1;
          end else if (plain) begin
            next_crc   = crc_step;
            fifo_rx_wr = 1'b1;
            next_state = NHR_RX_DATA;
          end else if (rx_in.data == 8'h00) begin
            next_cnt = (cnt == `NHR_PRE_MIN) ? cnt : cnt + 13'h0001;
          end else if ((rx_in.data == `NHR_SYNC1) && (cnt == `NHR_PRE_MIN)) begin
            next_state = NHR_RX_SYNC;
          end else begin
            next_cnt = 13'h0000;
          end
        end
      end
      NHR_RX_SYNC: begin
        if (rx_in.done) begin
          next_state = NHR_RX_HUNT;
        end else if (rx_in.valid) begin
          next_state = (rx_in.data == `NHR_SYNC2) ? NHR_RX_LEN : NHR_RX_HUNT;
          next_cnt   = 13'h0000;
        end
      end
      NHR_RX_LEN: begin
        if (rx_in.done) begin
          set_fsm[`NHR_F_END_RX] = 1'b1;
          set_fsm[`NHR_F_CRC]    = 1'b1;
          next_state = NHR_IDLE;
        end else if (rx_in.valid) begin
          fifo_rx_wr = 1'b1;
          next_crc   = crc_step;
          if (rx_in.data < `NHR_LEN_MIN) begin
            set_fsm[`NHR_F_LEN] = 1'b1;
            next_state = NHR_IDLE;
          end else begin
            next_cnt   = {5'h00, rx_in.data} + 13'h0001;
            next_state = NHR_RX_DATA;
          end
        end
      end
      NHR_RX_DATA: begin
        if (rx_in.done) begin
          // Early end of a counted frame counts as a bad check
          set_fsm[`NHR_F_END_RX] = 1'b1;
          set_fsm[`NHR_F_CRC]    = !plain || (crc != 16'h0000);
          next_state = NHR_IDLE;
        end else if (rx_in.valid) begin
          next_crc   = crc_step;
          fifo_rx_wr = plain || (cnt > 13'h0002);
          if (!plain) begin
            next_cnt = cnt - 13'h0001;
            if (cnt == 13'h0001) begin
              set_fsm[`NHR_F_END_RX] = 1'b1;
              set_fsm[`NHR_F_CRC]    = (crc_step != 16'h0000);
              next_state = NHR_IDLE;
            end
          end
        end
      end
      default: next_state = NHR_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= NHR_IDLE;
      cnt   <= 13'h0000;
      crc   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      crc   <= next_crc;
    end
  end

  // Modulator handshake: a byte stands until tx_ready takes it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_out <= '0;
    end else if (tx_load) begin
      tx_out.valid <= 1'b1;
      tx_out.data  <= tx_byte;
    end else if (tx_ready) begin
      tx_out.valid <= 1'b0;
    end
  end

  // Field detector pin crosses in on two flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      efd_meta <= 1'b0;
      efd      <= 1'b0;
    end else begin
      efd_meta <= ext_field_pin;
      efd      <= efd_meta;
    end
  end

  // Field switch and guard wait; refused while a foreign field is seen
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      field_on  <= 1'b0;
      guard_cnt <= '0;
    end else if (cmd_foff) begin
      field_on  <= 1'b0;
      guard_cnt <= '0;
    end else if (fon_ok) begin
      field_on  <= 1'b1;
      guard_cnt <= GUARD_CYCLES[GW-1:0];
    end else if (guard_busy) begin
      guard_cnt <= guard_cnt - GW'(1);
    end
  end

  // Software registers; a flag set wins over its clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl   <= `NHR_CTRL_RST;
      txc_lo <= 8'h00;
      txc_hi <= 8'h00;
      flags  <= 8'h00;
    end else begin
      if (reg_wr && sel_ctrl) ctrl <= reg_wdata;
      if (reg_wr && sel_txlo) txc_lo <= reg_wdata;
      if (reg_wr && sel_txhi) txc_hi <= reg_wdata;
      flags <= (flags & ~clr_all) | set_all;
    end
  end

  // Rate and modulation follow the mode field
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rate_div  <= 2'h0;
      mod_am    <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      rate_div  <= a106 ? 2'h0 : ((ctrl[1:0] == NHR_HR212) ? 2'h1 : 2'h2);
      mod_am    <= hr;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // FIFO pointers and fill level
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wptr   <= 7'h00;
      rptr   <= 7'h00;
      fcount <= 7'h00;
    end else if (cmd_fclr) begin
      wptr   <= 7'h00;
      rptr   <= 7'h00;
      fcount <= 7'h00;
    end else begin
      if (fifo_we) wptr <= ptr_inc(wptr);
      if (fifo_re) rptr <= ptr_inc(rptr);
      fcount <= fcount + {6'h00, fifo_we} - {6'h00, fifo_re};
    end
  end

  // Storage has no reset, only the pointers matter
  always_ff @(posedge ref_clk) begin
    if (fifo_we) fifo_mem[wptr] <= fifo_wdata;
  end

  // Checks on the framer's own behaviour
  sequence s_syn1_load;
    (state == NHR_TX_SYN1) && tx_load;
  endsequence
  sequence s_syn_pair;
    (tx_out.data == `NHR_SYNC1) ##[1:300] ((state == NHR_TX_LEN) && tx_load);
  endsequence

  AST_SYNC_ORDER: assert property (@(posedge ref_clk) disable iff (reset)
    s_syn1_load |=> s_syn_pair)
    else $error("sync bytes out of order");
  AST_LEN_BYTE: assert property (@(posedge ref_clk) disable iff (reset)
    ((state == NHR_TX_LEN) && tx_load) |=> (tx_out.data == $past(len_tx)))
    else $error("length byte is not count plus one");
  AST_START_BYTE: assert property (@(posedge ref_clk) disable iff (reset)
    ((state == NHR_TX_SB) && tx_load) |=> (tx_out.valid && tx_out.data == `NHR_SB))
    else $error("start byte not sent first");
  AST_PRE_START: assert property (@(posedge ref_clk) disable iff (reset)
    (cmd_tx && hr && !tf106) |=> (state == NHR_TX_PRE) && (cnt == pre_bytes(pre_sel)))
    else $error("preamble length not taken from select");
  AST_REFUSE: assert property (@(posedge ref_clk) disable iff (reset)
    (cmd_fon && efd && !field_on) |=> !field_on && flags[`NHR_F_REFUSE])
    else $error("field switched on under external field");
  AST_HUNT_AFTER_TX: assert property (@(posedge ref_clk) disable iff (reset)
    ((state == NHR_TX_END) && tx_ready) |=> (state == NHR_RX_HUNT) && !tx_out.valid)
    else $error("no reply hunt after transmit");
  AST_LEN_RANGE: assert property (@(posedge ref_clk) disable iff (reset)
    ((state == NHR_RX_LEN) && rx_in.valid && !rx_in.done && rx_in.data < `NHR_LEN_MIN)
    |=> (state == NHR_IDLE) && flags[`NHR_F_LEN])
    else $error("short length byte accepted");
  AST_SOFT_ERR: assert property (@(posedge ref_clk) disable iff (reset)
    ((state == NHR_RX_HUNT) && tf106 && rx_in.valid && rx_in.data != `NHR_SB)
    |=> flags[`NHR_F_SOFT] && (state == NHR_RX_LEN))
    else $error("bad start byte not flagged");
  AST_CRC_ERR: assert property (@(posedge ref_clk) disable iff (reset)
    ((state == NHR_RX_DATA) && !plain && rx_in.valid && !rx_in.done
     && (cnt == 13'h0001) && (crc_step != 16'h0000))
    |=> flags[`NHR_F_CRC] && flags[`NHR_F_END_RX])
    else $error("bad check not flagged");
  AST_TX_GATED: assert property (@(posedge ref_clk) disable iff (reset)
    ((state == NHR_IDLE) && guard_busy && wr_cmd && reg_wdata == `NHR_CMD_TX_CRC)
    |=> (state == NHR_IDLE))
    else $error("transmit inside guard time");
endmodule

// ===== shared/nhr_cfg.svh
// Offsets, field positions, reset values and timing counts of the framer.
// Assumes an 8-bit register port and a 100 MHz ref_clk.
`ifndef NHR_CFG_SVH
`define NHR_CFG_SVH
// Register offsets
`define NHR_OFF_CTRL   8'h00
`define NHR_OFF_TXC_LO 8'h04
`define NHR_OFF_TXC_HI 8'h08
`define NHR_OFF_CMD    8'h0C
`define NHR_OFF_FIFO   8'h10
`define NHR_OFF_FST1   8'h14
`define NHR_OFF_FST2   8'h18
`define NHR_OFF_FLAGS  8'h1C
`define NHR_OFF_STAT   8'h20
// Control fields and reset value
`define NHR_CTRL_RST   8'h00
`define NHR_BIT_TF106  2
`define NHR_BIT_PRE_LO 4
`define NHR_BIT_PRE_HI 5
// Direct commands
`define NHR_CMD_TX_CRC 8'h01
`define NHR_CMD_FON    8'h02
`define NHR_CMD_FOFF   8'h03
`define NHR_CMD_FCLR   8'h04
// Flag positions
`define NHR_F_END_RX   0
`define NHR_F_CRC      1
`define NHR_F_SOFT     2
`define NHR_F_LEN      3
`define NHR_F_REFUSE   4
`define NHR_F_TX_DONE  5
`define NHR_F_GUARD    6
`define NHR_F_OVF      7
// Frame constants
`define NHR_SYNC1      8'hB2
`define NHR_SYNC2      8'h4D
`define NHR_SB         8'hF0
`define NHR_LEN_MIN    8'h02
`define NHR_PRE_MIN    13'h0002
`define NHR_PRE_B0     13'h0006
`define NHR_PRE_B1     13'h0008
`define NHR_PRE_B2     13'h000A
`define NHR_PRE_B3     13'h000C
`define NHR_CRC_HR_INIT 16'h0000
`define NHR_CRC_HR_POLY 16'h1021
`define NHR_CRC_A_INIT  16'h6363
`define NHR_CRC_A_POLY  16'h8408
`define NHR_FIFO_DEPTH  7'h60
// Timing
`define NHR_CLK_PERIOD_NS 10
`define NHR_GUARD_TIME_US 5000
`define NHR_GUARD_CYCLES  ((`NHR_GUARD_TIME_US * 1000) / `NHR_CLK_PERIOD_NS)
`endif

// ===== shared/nhr_pkg.sv
// Types shared by the framer and its bench.
// Assumes nhr_cfg.svh holds all numeric constants.
package nhr_pkg;
  typedef enum logic [3:0] {
    NHR_IDLE    = 4'h0,
    NHR_TX_PRE  = 4'h1,
    NHR_TX_SYN1 = 4'h2,
    NHR_TX_SYN2 = 4'h3,
    NHR_TX_SB   = 4'h4,
    NHR_TX_LEN  = 4'h5,
    NHR_TX_DATA = 4'h6,
    NHR_TX_CRC1 = 4'h7,
    NHR_TX_CRC2 = 4'h8,
    NHR_TX_END  = 4'h9,
    NHR_RX_HUNT = 4'hA,
    NHR_RX_SYNC = 4'hB,
    NHR_RX_LEN  = 4'hC,
    NHR_RX_DATA = 4'hD
  } nhr_state_t;
  typedef enum logic [1:0] {
    NHR_A106  = 2'h0,
    NHR_HR212 = 2'h1,
    NHR_HR424 = 2'h2
  } nhr_mode_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } nhr_tx_link_t;
  typedef struct packed {
    logic       valid;
    logic       done;
    logic [7:0] data;
  } nhr_rx_link_t;
endpackage

// ===== dv/nhr_tag.sv
// Tag side model: collects the bytes sent on air, plays back replies.
// Assumes the framer's byte streams run on ref_clk.
`timescale 1ns/1ps
module nhr_tag
  import nhr_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire nhr_tx_link_t tx_out,
  output logic              tx_ready,
  output nhr_rx_link_t      rx_in
);
  logic [7:0] got[$];
  logic       slow;
  // Quiet line at start
  initial begin
    tx_ready = 1'b0;
    slow     = 1'b0;
    rx_in    = '0;
  end
  // Take bytes; a slow tag stalls at random
  always @(posedge ref_clk) begin
    if (tx_ready && tx_out.valid) got.push_back(tx_out.data);
    tx_ready <= !slow || $urandom_range(1);
  end
  // Reply one byte per ref_clk cycle; data toggles once released
  task automatic reply(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge ref_clk);
      rx_in <= '{1'b1, 1'b0, b[i]};
    end
    @(posedge ref_clk);
    rx_in <= '{1'b0, 1'b1, ~b[b.size()-1]};
    @(posedge ref_clk);
    rx_in <= '{1'b0, 1'b0, b[b.size()-1]};
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench: register port master, tag model on the air side.
// Assumes nhr_cfg.svh offsets and a guard time cut to 20 cycles.
`timescale 1ns/1ps
`include "nhr_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb
  import nhr_pkg::*;
;
  logic         ref_clk, reset, reg_wr, reg_rd, ext_field_pin;
  logic         field_on, mod_am, tx_ready;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata;
  logic [1:0]   rate_div;
  nhr_tx_link_t tx_out;
  nhr_rx_link_t rx_in;
  int           n_fail, n_checks, cyc;
  logic [7:0]   cfg [8] = '{8'h01, 8'h32, 8'h16, 8'h23, 8'h04, 8'h00, 8'h02, 8'h04};

  nhr_framer #(.GUARD_CYCLES(20)) i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rx_in, .tx_ready, .tx_out, .ext_field_pin,
    .field_on, .rate_div, .mod_am);
  nhr_tag tag (.ref_clk, .tx_out, .tx_ready, .rx_in);

  always #5 ref_clk = ~ref_clk;
  // Ceiling far above the planned run, so a hang cannot pass
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Strobes drop an edge before the next task may raise them
  task automatic wr(input logic [7:0] a, v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, e, m = 8'hFF);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(reg_rdata & m, e)
    @(posedge ref_clk);
  endtask
  // Both trailer flavours: CCITT msb-first, reflected type A
  function automatic logic [15:0] crc(input bit a, input logic [7:0] b[$]);
    logic [15:0] c;
    c = a ? 16'h6363 : 16'h0000;
    foreach (b[i]) begin
      c ^= a ? {8'h00, b[i]} : {b[i], 8'h00};
      repeat (8) c = a ? (c[0] ? (c >> 1) ^ 16'h8408 : c >> 1)
                       : (c[15] ? (c << 1) ^ 16'h1021 : c << 1);
    end
    return c;
  endfunction
  // Send a frame, check it on air, answer it, read the answer back
  // Short marks a reply whose length byte is below the legal minimum
  task automatic xfer(input logic [7:0] ctl, input bit bad, input bit shrt = 1'b0);
    logic [7:0]  p[$], e[$], r[$], q[$];
    logic [15:0] c;
    bit          hr, tf;
    int          n;
    hr = ctl[1:0] != 2'h0;
    tf = !hr && ctl[2];
    n  = 1 + $urandom_range(7);
    wr(`NHR_OFF_CTRL, ctl);
    wr(`NHR_OFF_CMD, `NHR_CMD_FCLR);
    wr(`NHR_OFF_FLAGS, 8'hFF);
    for (int i = 0; i < n; i++) begin
      p.push_back(8'($urandom));
      wr(`NHR_OFF_FIFO, p[i]);
    end
    if (hr) begin
      repeat (6 + 2 * ctl[5:4]) e.push_back(8'h00);
      q = {8'(n + 1), p};
      c = crc(0, q);
      e = {e, 8'hB2, 8'h4D, q, c[15:8], c[7:0]};
    end else begin
      q = tf ? {8'hF0, 8'(n + 1), p} : p;
      c = crc(1, q);
      e = {q, c[7:0], c[15:8]};
    end
    wr(`NHR_OFF_TXC_LO, 8'(n));
    wr(`NHR_OFF_TXC_HI, 8'h00);
    tag.got.delete();
    wr(`NHR_OFF_CMD, `NHR_CMD_TX_CRC);
    for (int k = 0; k < 500 && tag.got.size() < e.size(); k++) @(posedge ref_clk);
    `CHK(tag.got.size(), e.size())
    foreach (e[i]) `CHK(tag.got[i], e[i])
    `CHK(rate_div, hr ? (ctl[1] ? 2'h2 : 2'h1) : 2'h0)
    `CHK(mod_am, hr)
    // Reply body: length byte then payload; bad spoils CRC or start byte
    r = {shrt ? 8'h01 : 8'(2 + $urandom_range(3))};
    repeat (r[0] - 1) r.push_back(8'($urandom));
    if (hr) begin
      c = crc(0, r) ^ {15'h0, bad};
      q = {8'h00, 8'h00, 8'hB2, 8'h4D, r, c[15:8], c[7:0]};
    end else begin
      if (tf) r.push_front(bad ? 8'hF1 : 8'hF0);
      c = crc(1, r);
      q = {r, c[7:0], c[15:8]};
      r = tf ? r[1:$] : q;
    end
    tag.reply(q);
    repeat (3) @(posedge ref_clk);
    rd(`NHR_OFF_FST1, 8'(r.size()));
    foreach (r[i]) rd(`NHR_OFF_FIFO, r[i]);
    rd(`NHR_OFF_FLAGS, {2'h0, 1'b1, 1'b0, shrt, bad && tf, bad && hr, !shrt}, 8'h2F);
  endtask

  initial begin
    void'($urandom(32'hD2071B04));
    ref_clk       = 1'b0;
    reset         = 1'b1;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_addr      = 8'h00;
    reg_wdata     = 8'h00;
    ext_field_pin = 1'b0;
    cyc           = 0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(`NHR_OFF_CTRL, `NHR_CTRL_RST);
    rd(8'hFC, 8'h00);
    `CHK({rate_div, mod_am, field_on, tx_out.valid}, 5'h00)
    // Field request under an outside field is refused
    ext_field_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`NHR_OFF_STAT, 8'h80, 8'h80);
    wr(`NHR_OFF_CMD, `NHR_CMD_FON);
    rd(`NHR_OFF_FLAGS, 8'h10, 8'h10);
    `CHK(field_on, 1'b0)
    ext_field_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(`NHR_OFF_STAT, 8'h00, 8'h80);
    wr(`NHR_OFF_CMD, `NHR_CMD_FON);
    wr(`NHR_OFF_CMD, `NHR_CMD_TX_CRC);
    rd(`NHR_OFF_STAT, 8'h60);
    repeat (25) @(posedge ref_clk);
    rd(`NHR_OFF_STAT, 8'h40);
    rd(`NHR_OFF_FLAGS, 8'h40, 8'h40);
    `CHK(field_on, 1'b1)
    $display("test field done");
    foreach (cfg[i]) begin
      tag.slow <= i[0];
      xfer(cfg[i], i >= 6);
      $display("test %0d ctrl %0h done", i, cfg[i]);
    end
    xfer(8'h01, 1'b0, 1'b1);
    $display("test short length done");
    close_out();
  end
endmodule
